/* File: isr_pkg.sv */
// shared constants, line carrier and protocol states for the sequential read block
package isr_pkg;

    // system clock rate and manual reset interval (reset_timeout_period)
    localparam int SYS_CLK_MHZ = 100;
    localparam int RESET_TIMEOUT_MS = 200;
    localparam int RESET_TIMEOUT_CYCLES = RESET_TIMEOUT_MS * SYS_CLK_MHZ * 1000;

    // memory array geometry
    localparam int MEM_ADDR_W = 11;
    localparam int MEM_DATA_W = 8;
    localparam int MEM_LAST_LOC = 2047;
    localparam int PAGE_BITS = 4;

    // slave address byte layout
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam int DEV_TYPE_MSB = 7;
    localparam int DEV_TYPE_LSB = 4;
    localparam int DEV_HI_MSB = 3;
    localparam int DEV_HI_LSB = 1;
    localparam int DEV_RW_BIT = 0;

    // bits per byte on the wire and idle line level
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] LINE_IDLE = 2'h3;

    // scl and sda sampled together
    typedef struct packed {
        logic scl;
        logic sda;
    } isr_line_s;

    // bus protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_WORD,
        ST_WORD_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK,
        ST_WAIT
    } isr_state_e;

endpackage

/* File: isr_mem.sv */
// memory array with one write port and a registered read port
`timescale 1ns/1ns
module isr_mem #(
    parameter int AW = 11,
    parameter int DW = 8
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [DW-1:0] wdata_in,
    output logic [DW-1:0] rdata_out
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // array write, no reset so it maps onto ram
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    // read data always reflects the current address one cycle later
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= mem[addr_in];
        end
    end

endmodule

/* File: isr_seq_read_top.sv */
// serial memory slave read path with manual reset timer and access lockout
//
// Summary of operation
// RULE_01 - multi-byte read starts from current-address read or dummy-write random read
// RULE_02 - master ack after each byte makes device send one more 8-bit byte
// RULE_03 - bytes come out in ascending address order, N then N plus one
// RULE_04 - read counter increments across all address bits, whole array in one go
// RULE_05 - counter wraps from location 2047 to zero and keeps sending
// RULE_06 - either reset pin may serve as manual reset input
// RULE_07 - manual reset detected only on entering its active level
// RULE_08 - rising edge on high pin, falling edge on low pin
// RULE_09 - sensed edge starts a 200 ms timer
// RULE_10 - complementary reset output held active while timer runs
// RULE_11 - output deasserts after 200 ms even if input still held
// RULE_12 - memory access disabled while any reset condition is present
// RULE_13 - held manual reset beyond timeout means no acknowledge until release
// RULE_14 - master not acknowledging stops data, device waits for stop
// RULE_15 - counter holds last accessed location plus one
// RULE_16 - eleven-bit counter updated on every byte sent, final one included
// RULE_17 - new edge while timer runs is ignored, pulse not extended
`timescale 1ns/1ns
module isr_seq_read_top
    import isr_pkg::*;
#(
    parameter int RESET_TICKS = RESET_TIMEOUT_CYCLES,
    parameter int AW = MEM_ADDR_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic link_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic mr_use_hi_in,
    input wire logic rst_hi_pin_in,
    output logic rst_hi_pin_out,
    output logic rst_hi_pin_oe_out,
    input wire logic rst_lo_b_pin_in,
    output logic rst_lo_b_pin_out,
    output logic rst_lo_b_pin_oe_out
);

    localparam int TW = $clog2(RESET_TICKS + 1);
    localparam logic [TW-1:0] TMR_TERM = TW'(RESET_TICKS - 1);

    // ---------------- system clock side: manual reset supervisor ----------------

    logic [1:0] sel_sync;
    logic [1:0] hi_sync;
    logic [1:0] lo_sync;
    logic mr_level;
    logic mr_prev;
    logic mr_edge;
    logic running;
    logic [TW-1:0] tmr;
    logic lock_sys;

    // pin inputs pass two flip-flops before use
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel_sync <= 2'h0;
            hi_sync <= 2'h0;
            lo_sync <= 2'h3;
        end else begin
            sel_sync <= {sel_sync[0], mr_use_hi_in};
            hi_sync <= {hi_sync[0], rst_hi_pin_in};
            lo_sync <= {lo_sync[0], rst_lo_b_pin_in};
        end
    end

    // active level of whichever pin carries the manual request
    assign mr_level = sel_sync[1] ? hi_sync[1] : ~lo_sync[1]; // RULE_06 RULE_08

    // previous level for edge sensing
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mr_prev <= 1'h0;
        end else begin
            mr_prev <= mr_level;
        end
    end

    // only the transition into the active level counts
    assign mr_edge = mr_level & ~mr_prev; // RULE_07

    // interval timer, edges during a run are dropped
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            running <= 1'h0;
            tmr <= '0;
        end else if (!running) begin
            if (mr_edge) begin // RULE_09 RULE_17
                running <= 1'h1;
                tmr <= '0;
            end
        end else if (tmr == TMR_TERM) begin
            running <= 1'h0; // RULE_11
            tmr <= '0;
        end else begin
            tmr <= tmr + TW'(1);
        end
    end

    // complementary pin driven as output, the request pin left as input
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_hi_pin_out <= 1'h0;
            rst_hi_pin_oe_out <= 1'h0;
            rst_lo_b_pin_out <= 1'h1;
            rst_lo_b_pin_oe_out <= 1'h0;
        end else begin
            rst_hi_pin_out <= ~sel_sync[1] & running; // RULE_10
            rst_hi_pin_oe_out <= ~sel_sync[1];
            rst_lo_b_pin_out <= ~(sel_sync[1] & running); // RULE_10
            rst_lo_b_pin_oe_out <= sel_sync[1];
        end
    end

    // a reset is present while the timer runs or the request is held
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lock_sys <= 1'h1;
        end else begin
            lock_sys <= running | mr_level; // RULE_12 RULE_13
        end
    end

    // ---------------- link clock side: bus slave ----------------

    logic [1:0] lock_sync;
    logic lock_link;
    isr_line_s line_m;
    isr_line_s line_s;
    isr_line_s line_p;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    isr_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [2:0] dev_hi;
    logic rw_read;
    logic ack_seen;
    logic sda_drv;
    logic [AW-1:0] addr_cnt;
    logic [7:0] rd_data;
    logic rd_load;
    logic word_load;
    logic wr_commit;
    logic byte_done;

    // lockout level crosses into the link domain
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lock_sync <= 2'h3;
        end else begin
            lock_sync <= {lock_sync[0], lock_sys};
        end
    end

    assign lock_link = lock_sync[1];

    // bus lines pass two flip-flops, a third stage gives edges
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_m <= LINE_IDLE;
            line_s <= LINE_IDLE;
            line_p <= LINE_IDLE;
        end else begin
            line_m <= '{scl: scl_in, sda: sda_in};
            line_s <= line_m;
            line_p <= line_s;
        end
    end

    // line events
    assign scl_rise = line_s.scl & ~line_p.scl;
    assign scl_fall = ~line_s.scl & line_p.scl;
    assign start_cond = line_s.scl & line_p.scl & line_p.sda & ~line_s.sda;
    assign stop_cond = line_s.scl & line_p.scl & ~line_p.sda & line_s.sda;
    assign byte_done = scl_fall & (bit_cnt == BITS_PER_BYTE);

    // byte events that move the address counter or write the array
    assign rd_load = scl_fall & ~lock_link & sda_drv & (state == ST_DEV_ACK) & rw_read
        | scl_fall & ~lock_link & ack_seen & (state == ST_RD_ACK); // RULE_02
    assign word_load = scl_fall & sda_drv & (state == ST_WORD_ACK); // RULE_01
    assign wr_commit = scl_fall & sda_drv & (state == ST_WR_ACK) & ~lock_link; // RULE_12

    // protocol sequencer, shifters and sda drive
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            dev_hi <= 3'h0;
            rw_read <= 1'h0;
            ack_seen <= 1'h0;
            sda_drv <= 1'h0;
        end else if (start_cond) begin
            state <= ST_DEV;
            bit_cnt <= 4'h0;
            sda_drv <= 1'h0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            sda_drv <= 1'h0; // RULE_14
        end else begin
            unique case (state)
                ST_IDLE, ST_WAIT: begin
                    sda_drv <= 1'h0;
                end
                ST_DEV, ST_WORD, ST_WR: begin
                    if (scl_rise) begin
                        shift_in <= {shift_in[6:0], line_s.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_DEV) begin
                            state <= ST_DEV_ACK;
                            dev_hi <= shift_in[DEV_HI_MSB:DEV_HI_LSB];
                            rw_read <= shift_in[DEV_RW_BIT];
                            sda_drv <= ~lock_link
                                & (shift_in[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE_CODE); // RULE_13
                        end else begin
                            state <= (state == ST_WORD) ? ST_WORD_ACK : ST_WR_ACK;
                            sda_drv <= ~lock_link; // RULE_13
                        end
                    end
                end
                ST_DEV_ACK: begin
                    if (scl_fall) begin
                        if (rd_load) begin
                            state <= ST_RD; // RULE_01
                            shift_out <= rd_data;
                            sda_drv <= ~rd_data[7];
                        end else if (sda_drv & ~rw_read) begin
                            state <= ST_WORD;
                            sda_drv <= 1'h0;
                        end else begin
                            state <= ST_WAIT;
                            sda_drv <= 1'h0;
                        end
                    end
                end
                ST_WORD_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        state <= sda_drv ? ST_WR : ST_WAIT;
                        sda_drv <= 1'h0;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (lock_link) begin
                            state <= ST_WAIT; // RULE_12
                            sda_drv <= 1'h0;
                        end else if (byte_done) begin
                            state <= ST_RD_ACK;
                            bit_cnt <= 4'h0;
                            sda_drv <= 1'h0;
                        end else begin
                            shift_out <= {shift_out[6:0], 1'h0};
                            sda_drv <= ~shift_out[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        ack_seen <= ~line_s.sda;
                    end
                    if (scl_fall) begin
                        if (rd_load) begin
                            state <= ST_RD; // RULE_02
                            shift_out <= rd_data;
                            sda_drv <= ~rd_data[7];
                        end else begin
                            state <= ST_WAIT; // RULE_14
                            sda_drv <= 1'h0;
                        end
                        ack_seen <= 1'h0;
                    end
                end
            endcase
        end
    end

    // address counter: full-width step on reads, page step on writes
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            addr_cnt <= '0;
        end else if (word_load) begin
            addr_cnt <= {dev_hi, shift_in}; // RULE_01
        end else if (rd_load) begin
            addr_cnt <= addr_cnt + AW'(1); // RULE_03 RULE_04 RULE_05 RULE_15 RULE_16
        end else if (wr_commit) begin
            addr_cnt <= {addr_cnt[AW-1:PAGE_BITS],
                addr_cnt[PAGE_BITS-1:0] + PAGE_BITS'(1)}; // RULE_15
        end
    end

    // open-drain data line only ever pulls low
    assign sda_out = 1'h0;
    assign sda_oe_out = sda_drv;

    isr_mem #(
        .AW(AW),
        .DW(MEM_DATA_W)
    ) isr_mem_i (
        .clk_in(link_clk_in),
        .rst_b_in(rst_b_in),
        .we_in(wr_commit),
        .addr_in(addr_cnt),
        .wdata_in(shift_in),
        .rdata_out(rd_data)
    );

    // ---------------- checks on the supervisor ----------------

    timer_start_a: assert property ( // RULE_09
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!running && mr_edge) |=> (running && tmr == '0)
    ) else $error("manual edge did not start the timer");

    edge_only_a: assert property ( // RULE_07
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (!running && !mr_edge) |=> !running
    ) else $error("timer started without an active edge");

    edge_polarity_a: assert property ( // RULE_08
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        mr_edge |-> (sel_sync[1] ? (hi_sync[1] && !$past(hi_sync[1]))
            : (!lo_sync[1] && $past(lo_sync[1])))
    ) else $error("edge sensed with wrong polarity");

    comp_out_a: assert property ( // RULE_10
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        running |=> (sel_sync[1] ? (!rst_lo_b_pin_out && rst_lo_b_pin_oe_out)
            : (rst_hi_pin_out && rst_hi_pin_oe_out))
    ) else $error("complementary output not active while timing");

    timer_end_a: assert property ( // RULE_11
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (running && tmr == TMR_TERM) |=> !running ##1 (rst_lo_b_pin_out && !rst_hi_pin_out)
    ) else $error("output did not release at end of interval");

    no_extend_a: assert property ( // RULE_17
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (running && mr_edge && tmr != TMR_TERM) |=> (running && tmr == $past(tmr) + TW'(1))
    ) else $error("edge during run restarted the timer");

    // ---------------- checks on the bus slave ----------------

    no_write_lock_a: assert property ( // RULE_12
        @(posedge link_clk_in) disable iff (!rst_b_in)
        lock_link |-> !wr_commit
    ) else $error("array written while reset present");

    no_ack_lock_a: assert property ( // RULE_13
        @(posedge link_clk_in) disable iff (!rst_b_in)
        (lock_link && byte_done && state == ST_DEV) |=> (state == ST_DEV_ACK && !sda_drv)
    ) else $error("address acknowledged while locked out");

    addr_step_a: assert property ( // RULE_03
        @(posedge link_clk_in) disable iff (!rst_b_in)
        rd_load |=> addr_cnt == $past(addr_cnt) + AW'(1)
    ) else $error("read address did not advance by one");

    addr_wrap_a: assert property ( // RULE_05
        @(posedge link_clk_in) disable iff (!rst_b_in)
        (rd_load && addr_cnt == AW'(MEM_LAST_LOC)) |=> addr_cnt == '0
    ) else $error("read address did not wrap to zero");

    ack_more_a: assert property ( // RULE_02
        @(posedge link_clk_in) disable iff (!rst_b_in)
        (state == ST_RD_ACK && rd_load && !start_cond && !stop_cond)
            |=> (state == ST_RD && bit_cnt == 4'h0)
    ) else $error("acknowledge did not start another byte");

    nack_stop_a: assert property ( // RULE_14
        @(posedge link_clk_in) disable iff (!rst_b_in)
        (state == ST_RD_ACK && scl_fall && !ack_seen && !start_cond && !stop_cond)
            |=> (state == ST_WAIT && !sda_drv)
    ) else $error("device kept sending after no acknowledge");

endmodule

/* File: isr_i2c_master.sv */
// bus master model that clocks scl and pulls sda low
`timescale 1ns/1ns
module isr_i2c_master (
    input wire logic link_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    int half = 5; // link periods per clock phase, raised for a slow master

    // bus idle with both lines released
    initial begin
        scl_out = 1'h1;
        sda_low_out = 1'h0;
    end

    // lines change just after a link edge
    task automatic tick();
        repeat (half) @(posedge link_clk_in);
        #1;
    endtask

    // start or repeated start, ends with scl low
    task automatic start_c();
        sda_low_out = 1'h0;
        tick();
        scl_out = 1'h1;
        tick();
        sda_low_out = 1'h1;
        tick();
        scl_out = 1'h0;
        tick();
    endtask

    // stop closes every transfer, also after a nack
    task automatic stop_c();
        sda_low_out = 1'h1;
        tick();
        scl_out = 1'h1;
        tick();
        sda_low_out = 1'h0;
        tick();
    endtask

    // one clock pulse, sda sampled at the end of the high phase
    task automatic pulse(output logic s);
        scl_out = 1'h1;
        tick();
        s = sda_in;
        scl_out = 1'h0;
        tick();
    endtask

    // byte out msb first, acked is 1 when the device pulled sda low
    task automatic send(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_low_out = ~b[i];
            tick();
            pulse(s);
        end
        sda_low_out = 1'h0;
        tick();
        pulse(s);
        acked = ~s;
    endtask

    // byte in, then ack to ask for more or nack to end
    task automatic recv(input logic give_ack, output logic [7:0] b);
        logic s;
        sda_low_out = 1'h0;
        tick();
        for (int i = 7; i >= 0; i--) begin
            pulse(s);
            b[i] = s;
        end
        // the ack stays low until the next recv or stop takes the line over
        sda_low_out = give_ack;
        tick();
        pulse(s);
    endtask
endmodule

/* File: isr_seq_read_top_tb_top.sv */
// self-checking bench for the sequential read block
`timescale 1ns/1ns
module isr_seq_read_top_tb_top;
    import isr_pkg::*;
    localparam int TICKS = 1500;
    logic sys_clk, link_clk, rst_b, use_hi, hi_drv, lo_b_drv;
    logic sda_o, sda_oe, hi_o, hi_oe, lo_o, lo_oe, scl, m_low;
    logic sda_wire, hi_wire, lo_wire;
    logic [7:0] mem_m [0:2047];
    int ptr_m;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 1170;

    // pulled-up data line and reset pins resolved from the enables
    assign sda_wire = ~(m_low | (sda_oe & ~sda_o));
    assign hi_wire = hi_oe ? hi_o : hi_drv;
    assign lo_wire = lo_oe ? lo_o : lo_b_drv;

    isr_seq_read_top #(.RESET_TICKS(TICKS)) isr_seq_read_top_i (
        .sys_clk_in(sys_clk), .rst_b_in(rst_b), .link_clk_in(link_clk),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .mr_use_hi_in(use_hi), .rst_hi_pin_in(hi_wire), .rst_hi_pin_out(hi_o),
        .rst_hi_pin_oe_out(hi_oe), .rst_lo_b_pin_in(lo_wire),
        .rst_lo_b_pin_out(lo_o), .rst_lo_b_pin_oe_out(lo_oe)
    );
    isr_i2c_master isr_i2c_master_i (
        .link_clk_in(link_clk), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(m_low)
    );

    // system clock and an unrelated link clock
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'h0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    // compare helpers, one per kind of result
    task automatic chk_bit(string what, logic exp, logic got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0b seen %0b", what, exp, got);
        end
    endtask
    task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_cnt(string what, int exp, int got);
        n_compared++;
        if (got != exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // page write with random data, low four address bits step
    task automatic page_write(logic [10:0] a, int n);
        logic ack;
        logic [7:0] b;
        isr_i2c_master_i.start_c();
        isr_i2c_master_i.send({DEV_TYPE_CODE, a[10:8], 1'h0}, ack);
        chk_bit("write select ack", 1'h1, ack);
        isr_i2c_master_i.send(a[7:0], ack);
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            isr_i2c_master_i.send(b, ack);
            mem_m[{a[10:4], 4'(a[3:0] + i)}] = b;
        end
        isr_i2c_master_i.stop_c();
    endtask

    // multi-byte read, a below zero reads from the current counter
    task automatic seq_read(int a, int n);
        logic ack;
        logic [7:0] b;
        logic [10:0] wa;
        wa = 11'(a);
        if (a >= 0) begin
            isr_i2c_master_i.start_c();
            isr_i2c_master_i.send({DEV_TYPE_CODE, wa[10:8], 1'h0}, ack);
            chk_bit("dummy select ack", 1'h1, ack);
            isr_i2c_master_i.send(wa[7:0], ack);
            ptr_m = a;
        end
        isr_i2c_master_i.start_c();
        isr_i2c_master_i.send({DEV_TYPE_CODE, 3'($random(seed)), 1'h1}, ack);
        chk_bit("read select ack", 1'h1, ack);
        for (int i = 0; i < n; i++) begin
            isr_i2c_master_i.recv(i < n - 1, b);
            chk_byte("read data", mem_m[ptr_m], b);
            ptr_m = (ptr_m + 1) % 2048;
        end
        isr_i2c_master_i.stop_c();
    endtask

    // select that a locked device must refuse
    task automatic try_select();
        logic ack;
        isr_i2c_master_i.start_c();
        isr_i2c_master_i.send({DEV_TYPE_CODE, 3'h0, 1'h1}, ack);
        chk_bit("locked select ack", 1'h0, ack);
        isr_i2c_master_i.stop_c();
    endtask

    function automatic logic active(logic hi_mode);
        return hi_mode ? (lo_o === 1'h0) : (hi_o === 1'h1);
    endfunction

    task automatic drive(logic hi_mode, logic on);
        if (hi_mode) begin
            hi_drv = on;
        end else begin
            lo_b_drv = ~on;
        end
    endtask

    // counts system cycles that the complementary output stays active
    task automatic measure(logic hi_mode, output int cnt);
        int w;
        cnt = 0;
        w = 0;
        while (!active(hi_mode) && w < 50) begin
            @(posedge sys_clk);
            #1;
            w++;
        end
        while (active(hi_mode) && cnt < 2 * TICKS) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
    endtask

    // manual reset: short press with a second edge, or a long hold
    task automatic mr_test(logic hi_mode, int hold);
        int cnt;
        @(posedge sys_clk);
        #1;
        use_hi = hi_mode;
        repeat (10) @(posedge sys_clk);
        #1;
        chk_bit("output enable", 1'h1, hi_mode ? lo_oe : hi_oe);
        drive(hi_mode, 1'h1);
        fork
            measure(hi_mode, cnt);
            if (hold < TICKS) begin
                repeat (hold) @(posedge sys_clk);
                #1;
                drive(hi_mode, 1'h0);
                repeat (hold) @(posedge sys_clk);
                #1;
                drive(hi_mode, 1'h1);
                repeat (hold) @(posedge sys_clk);
                #1;
                drive(hi_mode, 1'h0);
                try_select();
            end
        join
        chk_cnt("reset pulse width", TICKS, cnt);
        if (hold >= TICKS) begin
            try_select();
            chk_bit("output after timeout", 1'h0, active(hi_mode));
            drive(hi_mode, 1'h0);
        end
        repeat (20) @(posedge sys_clk);
        seq_read(-1, 2);
        $display("test manual reset mode %0b hold %0d done", hi_mode, hold);
    endtask

    // main sequence
    initial begin
        rst_b = 1'h0;
        use_hi = 1'h0;
        hi_drv = 1'h0;
        lo_b_drv = 1'h1;
        repeat (6) @(posedge sys_clk);
        repeat (2) @(posedge link_clk);
        #1;
        rst_b = 1'h1;
        repeat (20) @(posedge link_clk);
        page_write(11'h7F0, 16);
        page_write(11'h000, 8);
        $display("test page writes done");
        seq_read(2040, 12);
        seq_read(-1, 4);
        $display("test sequential reads done");
        isr_i2c_master_i.half = 9;
        seq_read(2046, 3);
        isr_i2c_master_i.half = 5;
        $display("test slow master read done");
        mr_test(1'h0, TICKS + 100);
        mr_test(1'h1, 5);
        tally_and_finish();
    end

    // watchdog well beyond the expected run length
    initial begin
        #900000;
        n_fail++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule
